/* File: design/dhp_pkg.sv */
package dhp_pkg;

  // bus, select and interrupt-source widths
  localparam int DATA_W  = 8;
  localparam int IDX_W   = 3;
  localparam int SRC_W   = 4;

  // channel-select encoding
  localparam logic CHAN_A = 1'b0;
  localparam logic CHAN_B = 1'b1;

  // direction input encoding
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  // values after reset
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;
  localparam logic [IDX_W-1:0]  IDX_RST   = 3'h0;
  localparam logic              SEL_IDLE  = 1'b1;
  localparam logic              IRQ_LEVEL = 1'b0;

  // access sequencer states
  typedef enum logic [1:0] {
    DHP_IDLE,
    DHP_RD_CAPTURE,
    DHP_RD_HOLD,
    DHP_WR_WAIT
  } dhp_state_t;

endpackage

/* File: design/dhp_access_if.sv */
interface dhp_access_if;
  import dhp_pkg::*;

  logic              wr_pulse;
  logic              rd_pulse;
  logic              chan;
  logic [IDX_W-1:0]  index;
  logic [DATA_W-1:0] wdata;

  modport decoder (
    output wr_pulse,
    output rd_pulse,
    output chan,
    output index,
    output wdata
  );

  modport channel (
    input wr_pulse,
    input rd_pulse,
    input chan,
    input index,
    input wdata
  );
endinterface

/* File: design/dhp_chan_slice.sv */
module dhp_chan_slice #(
  parameter logic CHAN_ID = 1'b0
) (
  // clock, enable and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  input  wire logic                       ce_i,
  // decoded host access
  dhp_access_if.channel                   acc,
  // channel interrupt sources and enables
  input  wire logic [dhp_pkg::SRC_W-1:0]  int_src_i,
  input  wire logic [dhp_pkg::SRC_W-1:0]  int_en_i,
  // register strobes towards the channel, and the channel's service request
  output logic                            wr_stb_o,
  output logic                            rd_stb_o,
  output logic [dhp_pkg::IDX_W-1:0]       index_o,
  output logic [dhp_pkg::DATA_W-1:0]      wdata_o,
  output logic                            irq_req_o
);
  import dhp_pkg::*;

  logic hit;
  assign hit = (acc.chan == CHAN_ID);

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
    end else if (ce_i) begin
      wr_stb_o <= acc.wr_pulse && hit;
      rd_stb_o <= acc.rd_pulse && hit;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      index_o <= IDX_RST;
      wdata_o <= DATA_RST;
    end else if (ce_i && hit && (acc.wr_pulse || acc.rd_pulse)) begin
      index_o <= acc.index;
      wdata_o <= acc.wdata;
    end
  end

  // only enabled sources count as a service request
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_req_o <= 1'b0;
    end else if (ce_i) begin
      irq_req_o <= |(int_src_i & int_en_i);
    end
  end

endmodule // dhp_chan_slice

/* File: design/dhp_host_port.sv */
// Behaviour
// - channel-select low reaches channel A, high reaches channel B
// - reads happen only while the active-low device select is asserted; writes commit on its release
// - 8-bit three-state data bus, bit 0 least significant
// - both channels' requests merge onto one shared interrupt output
// - interrupt pulled low when any enabled channel source needs service
// - three register-select bits choose the addressed channel's register
// - host polls each channel's status via channel-select to find source
// - direction low writes bus into register, high drives register out
module dhp_host_port (
  // clock, enable and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  input  wire logic                       ce_i,
  // host pins
  input  wire logic                       dev_sel_n_i,
  input  wire logic                       dir_read_i,
  input  wire logic                       channel_select_bit_i,
  input  wire logic                       reg_index_bit0_i,
  input  wire logic                       reg_index_bit1_i,
  input  wire logic                       reg_index_bit2_i,
  input  wire logic [dhp_pkg::DATA_W-1:0] host_data_bus_i,
  output logic [dhp_pkg::DATA_W-1:0]      host_data_bus_o,
  output logic                            host_data_bus_oe_o,
  output logic                            irq_n_o,
  output logic                            irq_n_oe_o,
  // channel A side
  input  wire logic [dhp_pkg::SRC_W-1:0]  chan_a_int_src_i,
  input  wire logic [dhp_pkg::SRC_W-1:0]  chan_a_int_en_i,
  input  wire logic [dhp_pkg::DATA_W-1:0] chan_a_rdata_i,
  output logic                            chan_a_wr_stb_o,
  output logic                            chan_a_rd_stb_o,
  output logic [dhp_pkg::IDX_W-1:0]       chan_a_index_o,
  output logic [dhp_pkg::DATA_W-1:0]      chan_a_wdata_o,
  // channel B side
  input  wire logic [dhp_pkg::SRC_W-1:0]  chan_b_int_src_i,
  input  wire logic [dhp_pkg::SRC_W-1:0]  chan_b_int_en_i,
  input  wire logic [dhp_pkg::DATA_W-1:0] chan_b_rdata_i,
  output logic                            chan_b_wr_stb_o,
  output logic                            chan_b_rd_stb_o,
  output logic [dhp_pkg::IDX_W-1:0]       chan_b_index_o,
  output logic [dhp_pkg::DATA_W-1:0]      chan_b_wdata_o
);
  import dhp_pkg::*;

  localparam int PIN_W = DATA_W + IDX_W + 3;

  dhp_access_if acc ();

  dhp_state_t        state;
  dhp_state_t        next_state;
  logic [PIN_W-1:0]  pins_raw;
  logic [PIN_W-1:0]  pins_meta;
  logic [PIN_W-1:0]  pins_sync;
  logic              sel_n_last;
  logic              sel_n;
  logic              sel_fall;
  logic              sel_rise;
  logic              dir_s;
  logic              chan_s;
  logic [IDX_W-1:0]  idx_s;
  logic [DATA_W-1:0] data_s;
  logic              rd_chan;
  logic              irq_a;
  logic              irq_b;

  // every host pin is asynchronous to clk_sys_i
  assign pins_raw = {dev_sel_n_i, dir_read_i, channel_select_bit_i,
                     reg_index_bit2_i, reg_index_bit1_i, reg_index_bit0_i,
                     host_data_bus_i};

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pins_meta <= {SEL_IDLE, {(PIN_W-1){1'b0}}};
      pins_sync <= {SEL_IDLE, {(PIN_W-1){1'b0}}};
    end else if (ce_i) begin
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  assign sel_n  = pins_sync[PIN_W-1];
  assign dir_s  = pins_sync[PIN_W-2];
  assign chan_s = pins_sync[PIN_W-3];
  assign idx_s  = pins_sync[DATA_W +: IDX_W];
  assign data_s = pins_sync[DATA_W-1:0];

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sel_n_last <= SEL_IDLE;
    end else if (ce_i) begin
      sel_n_last <= sel_n;
    end
  end

  assign sel_fall = sel_n_last && !sel_n;
  assign sel_rise = !sel_n_last && sel_n;

  // access sequencer
  always_comb begin
    next_state = state;
    case (state)
      DHP_IDLE: begin
        if (sel_fall) begin
          next_state = (dir_s == DIR_READ) ? DHP_RD_CAPTURE
                                           : DHP_WR_WAIT;
        end
      end
      DHP_RD_CAPTURE: begin
        next_state = DHP_RD_HOLD;
      end
      DHP_RD_HOLD: begin
        if (sel_n) begin
          next_state = DHP_IDLE;
        end
      end
      DHP_WR_WAIT: begin
        if (sel_n) begin
          next_state = DHP_IDLE;
        end
      end
      default: begin
        next_state = DHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= DHP_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // address is latched as select falls and held for the whole access
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      acc.chan  <= CHAN_A;
      acc.index <= IDX_RST;
    end else if (ce_i && state == DHP_IDLE && sel_fall) begin
      acc.chan  <= chan_s;
      acc.index <= idx_s;
    end
  end

  // a read is issued at select fall so data is ready early in the cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      acc.rd_pulse <= 1'b0;
    end else if (ce_i) begin
      acc.rd_pulse <= (state == DHP_IDLE) && sel_fall
                      && (dir_s == DIR_READ);
    end
  end

  // a write commits on select release, when the host data has settled
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      acc.wr_pulse <= 1'b0;
      acc.wdata    <= DATA_RST;
    end else if (ce_i) begin
      acc.wr_pulse <= (state == DHP_WR_WAIT) && sel_rise;
      if (state == DHP_WR_WAIT && sel_rise) begin
        acc.wdata <= data_s;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rd_chan <= CHAN_A;
    end else if (ce_i && acc.rd_pulse) begin
      rd_chan <= acc.chan;
    end
  end

  // the bus is driven only during a read and only while selected; data is
  // taken the cycle after the strobe, once the channel answers the new index
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      host_data_bus_o    <= DATA_RST;
      host_data_bus_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (chan_a_rd_stb_o || chan_b_rd_stb_o) begin
        host_data_bus_o <= (rd_chan == CHAN_B) ? chan_b_rdata_i
                                               : chan_a_rdata_i;
      end
      host_data_bus_oe_o <= (state == DHP_RD_HOLD)
                            && !sel_n;
    end
  end

  dhp_chan_slice #(
    .CHAN_ID (CHAN_A)
  ) u_slice_a (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .acc       (acc.channel),
    .int_src_i (chan_a_int_src_i),
    .int_en_i  (chan_a_int_en_i),
    .wr_stb_o  (chan_a_wr_stb_o),
    .rd_stb_o  (chan_a_rd_stb_o),
    .index_o   (chan_a_index_o),
    .wdata_o   (chan_a_wdata_o),
    .irq_req_o (irq_a)
  );

  dhp_chan_slice #(
    .CHAN_ID (CHAN_B)
  ) u_slice_b (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .acc       (acc.channel),
    .int_src_i (chan_b_int_src_i),
    .int_en_i  (chan_b_int_en_i),
    .wr_stb_o  (chan_b_wr_stb_o),
    .rd_stb_o  (chan_b_rd_stb_o),
    .index_o   (chan_b_index_o),
    .wdata_o   (chan_b_wdata_o),
    .irq_req_o (irq_b)
  );

  // open drain: the level is always low, only the enable moves, so the
  // pull-up alone sets the idle level; the host polls each channel
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_n_o    <= IRQ_LEVEL;
      irq_n_oe_o <= 1'b0;
    end else if (ce_i) begin
      irq_n_o    <= IRQ_LEVEL;
      irq_n_oe_o <= irq_a || irq_b;
    end
  end

endmodule // dhp_host_port

/* File: testbench/dhp_host_port_sva.sv */
module dhp_host_port_sva (
  // clock and host pins
  input wire logic                       clk_sys_i,
  input wire logic                       reset_i,
  input wire logic                       dev_sel_n_i,
  input wire logic                       dir_read_i,
  input wire logic                       channel_select_bit_i,
  input wire logic                       reg_index_bit0_i,
  input wire logic                       reg_index_bit1_i,
  input wire logic                       reg_index_bit2_i,
  input wire logic [dhp_pkg::DATA_W-1:0] host_data_bus_i,
  input wire logic [dhp_pkg::DATA_W-1:0] host_data_bus_o,
  input wire logic                       host_data_bus_oe_o,
  input wire logic                       irq_n_o,
  input wire logic                       irq_n_oe_o,
  // channel sides
  input wire logic [dhp_pkg::SRC_W-1:0]  chan_a_int_src_i,
  input wire logic [dhp_pkg::SRC_W-1:0]  chan_a_int_en_i,
  input wire logic [dhp_pkg::SRC_W-1:0]  chan_b_int_src_i,
  input wire logic [dhp_pkg::SRC_W-1:0]  chan_b_int_en_i,
  input wire logic [dhp_pkg::DATA_W-1:0] chan_a_rdata_i,
  input wire logic [dhp_pkg::DATA_W-1:0] chan_b_rdata_i,
  input wire logic                       chan_a_wr_stb_o,
  input wire logic                       chan_a_rd_stb_o,
  input wire logic                       chan_b_wr_stb_o,
  input wire logic                       chan_b_rd_stb_o,
  input wire logic [dhp_pkg::IDX_W-1:0]  chan_a_index_o,
  input wire logic [dhp_pkg::IDX_W-1:0]  chan_b_index_o,
  input wire logic [dhp_pkg::DATA_W-1:0] chan_a_wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dhp_pkg::*;
  logic [IDX_W-1:0] ix;
  logic             any_stb;
  assign ix = {reg_index_bit2_i, reg_index_bit1_i, reg_index_bit0_i};
  assign any_stb = chan_a_wr_stb_o | chan_a_rd_stb_o | chan_b_wr_stb_o
                 | chan_b_rd_stb_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_rd_route_a: assert property (
    chan_a_rd_stb_o |-> $past(channel_select_bit_i, 3) == CHAN_A
      && $past(ix, 3) == chan_a_index_o) else $error("bad read to a");
  a_rd_route_b: assert property (
    chan_b_rd_stb_o |-> $past(channel_select_bit_i, 3) == CHAN_B
      && $past(ix, 3) == chan_b_index_o) else $error("bad read to b");
  a_rd_under_sel: assert property (
    (chan_a_rd_stb_o || chan_b_rd_stb_o) |-> !$past(dev_sel_n_i, 3)
      && $past(dir_read_i, 3) == DIR_READ) else $error("stray read");
  a_wr_pulse_one: assert property (
    (chan_a_wr_stb_o || chan_b_wr_stb_o)
      |=> !(chan_a_wr_stb_o || chan_b_wr_stb_o)) else $error("long write");
  a_idle_no_stb: assert property (
    dev_sel_n_i [*8] |-> !any_stb) else $error("strobe while idle");
  a_wr_data_a: assert property (
    chan_a_wr_stb_o |-> chan_a_wdata_o == $past(host_data_bus_i, 4)
      && $past(dir_read_i, 4) == DIR_WRITE
      && $past(channel_select_bit_i, 4) == CHAN_A) else $error("bad write");
  a_read_drive: assert property (
    $rose(host_data_bus_oe_o) |-> host_data_bus_o == ($past(
      channel_select_bit_i) ? $past(chan_b_rdata_i) : $past(chan_a_rdata_i)))
    else $error("bad read data");
  a_oe_on_read: assert property (
    host_data_bus_oe_o |-> dir_read_i == DIR_READ) else $error("bus fight");
  a_irq_merge: assert property (
    irq_n_oe_o == $past(|(chan_a_int_src_i & chan_a_int_en_i)
      || |(chan_b_int_src_i & chan_b_int_en_i), 2)) else $error("bad irq");
  a_irq_no_high: assert property (
    irq_n_o == IRQ_LEVEL) else $error("irq driven high");
endmodule // dhp_host_port_sva

/* File: testbench/dhp_host_model.sv */
module dhp_host_model (
  input  wire logic                       clk_sys_i,
  input  wire logic [dhp_pkg::DATA_W-1:0] bus_i,
  output logic                            dev_sel_n_o,
  output logic                            dir_read_o,
  output logic                            chan_o,
  output logic [dhp_pkg::IDX_W-1:0]       idx_o,
  output logic [dhp_pkg::DATA_W-1:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import dhp_pkg::*;
  initial begin
    dev_sel_n_o = SEL_IDLE;
    dir_read_o = DIR_READ;
    chan_o = CHAN_A;
    idx_o = IDX_RST;
    data_o = DATA_RST;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // select held 8 clocks, longer than the read answer needs
  task automatic access(input logic rd, input logic ch,
      input logic [IDX_W-1:0] ix, input logic [DATA_W-1:0] wd,
      output logic [DATA_W-1:0] rv);
    @(negedge clk_sys_i);
    dir_read_o = rd;
    chan_o = ch;
    idx_o = ix;
    data_o = (rd == DIR_READ) ? ~data_o : wd;
    gap(4);
    dev_sel_n_o = 1'b0;
    gap(8);
    rv = bus_i;
    dev_sel_n_o = SEL_IDLE;
    gap(6); // data kept past the synced release
    data_o = ~data_o; // released pins must not look stable
    gap(3);
  endtask
endmodule // dhp_host_model

/* File: testbench/test_dual_uart_host_port_decode.sv */
module test_dual_uart_host_port_decode;
  timeunit 1ns;
  timeprecision 1ns;
  import dhp_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              reset_i = 1'b1;
  logic              sel_n, dir_rd, ch, doe, irq_n, irq_oe, irq_w;
  logic              a_wr, a_rs, b_wr, b_rs;
  logic [IDX_W-1:0]  ix, a_ix, b_ix;
  logic [DATA_W-1:0] hdata, bus, dout, a_rd, b_rd, a_wd, b_wd, d;
  logic [SRC_W-1:0]  a_src, a_en, b_src, b_en;
  int                errors = 0;
  int                total_checks = 0;
  assign bus = doe ? dout : hdata;
  assign irq_w = irq_oe ? irq_n : 1'b1; // pull-up when released
  assign a_rd = {5'h14, a_ix};
  assign b_rd = {5'h0b, b_ix};
  always #20 clk_sys_i = ~clk_sys_i;
  dhp_host_model host (.clk_sys_i, .bus_i(bus), .dev_sel_n_o(sel_n),
    .dir_read_o(dir_rd), .chan_o(ch), .idx_o(ix), .data_o(hdata));
  dhp_host_port dut (.clk_sys_i, .reset_i, .ce_i(1'b1),
    .dev_sel_n_i(sel_n), .dir_read_i(dir_rd), .channel_select_bit_i(ch),
    .reg_index_bit0_i(ix[0]), .reg_index_bit1_i(ix[1]),
    .reg_index_bit2_i(ix[2]), .host_data_bus_i(bus),
    .host_data_bus_o(dout), .host_data_bus_oe_o(doe), .irq_n_o(irq_n),
    .irq_n_oe_o(irq_oe), .chan_a_int_src_i(a_src), .chan_a_int_en_i(a_en),
    .chan_a_rdata_i(a_rd), .chan_a_wr_stb_o(a_wr), .chan_a_rd_stb_o(a_rs),
    .chan_a_index_o(a_ix), .chan_a_wdata_o(a_wd), .chan_b_int_src_i(b_src),
    .chan_b_int_en_i(b_en), .chan_b_rdata_i(b_rd), .chan_b_wr_stb_o(b_wr),
    .chan_b_rd_stb_o(b_rs), .chan_b_index_o(b_ix), .chan_b_wdata_o(b_wd));
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] e);
    total_checks++;
    if (got !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic t_read;
    for (int n = 0; n < 16; n++) begin
      host.access(DIR_READ, n[3], n[2:0], DATA_RST, d);
      chk(d, {n[3] ? 5'h0b : 5'h14, n[2:0]});
    end
    $display("test read done");
  endtask
  task automatic t_write;
    host.access(DIR_WRITE, CHAN_A, 3'h3, 8'h81, d);
    chk(a_wd, 8'h81);
    chk(a_ix, 3'h3);
    host.access(DIR_WRITE, CHAN_B, 3'h6, 8'h7e, d);
    chk(b_wd, 8'h7e);
    chk(a_wd, 8'h81);
    $display("test write done");
  endtask
  task automatic t_irq;
    logic [16:0] cases [4] = '{17'h01100, 17'h12100, 17'h00088, 17'h10000};
    foreach (cases[i]) begin
      {a_src, a_en, b_src, b_en} = cases[i][15:0];
      repeat (4) @(negedge clk_sys_i);
      chk(irq_w, cases[i][16]);
    end
    host.access(DIR_READ, CHAN_B, 3'h2, DATA_RST, d);
    chk(d, 8'h5a);
    $display("test irq done");
  endtask
  task automatic t_reset;
    @(negedge clk_sys_i);
    reset_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    chk(a_wd, DATA_RST);
    chk(irq_w, 1'b1);
    reset_i = 1'b0;
    host.access(DIR_READ, CHAN_A, 3'h7, DATA_RST, d);
    chk(d, 8'ha7);
    $display("test reset done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {a_src, a_en, b_src, b_en} = '0;
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_read;
    t_write;
    t_irq;
    t_reset;
    tally_and_finish;
  end
  // about 470 clocks of traffic; ten times that is a hang
  initial begin
    #200us;
    errors++;
    tally_and_finish;
  end
endmodule // test_dual_uart_host_port_decode
bind dhp_host_port dhp_host_port_sva sva (.clk_sys_i, .reset_i,
  .dev_sel_n_i, .dir_read_i, .channel_select_bit_i, .reg_index_bit0_i,
  .reg_index_bit1_i, .reg_index_bit2_i, .host_data_bus_i, .host_data_bus_o,
  .host_data_bus_oe_o, .irq_n_o, .irq_n_oe_o, .chan_a_int_src_i,
  .chan_a_int_en_i, .chan_b_int_src_i, .chan_b_int_en_i, .chan_a_rdata_i,
  .chan_b_rdata_i, .chan_a_wr_stb_o, .chan_a_rd_stb_o, .chan_b_wr_stb_o,
  .chan_b_rd_stb_o, .chan_a_index_o, .chan_b_index_o, .chan_a_wdata_o);
